// ### rtl/metering_regs.svh
`ifndef METERING_REGS_SVH
`define METERING_REGS_SVH
// Notes on behaviour
// RL1 - per-phase power sums latched every power interval
// RL2 - energy kept as low and high words
// RL3 - positive active total over three phases
// RL4 - negative active total over three phases
// RL5 - positive and negative reactive totals kept
// RL6 - user period replaces measured when selected
// RL7 - per-phase line period, resets 0x00A00000
// RL8 - combined-signal line period also measured
// RL9 - enable words gate status, cleared at reset
// RL10 - level constant feeds fundamental reactive path
// RL11 - fundamental reactive power and energy accumulated
// RL12 - status bits clear on write of one

// word offsets of the result bank
`define OFS_B_VAR_EGY_LO 12'h32C
`define OFS_B_VAR_EGY_HI 12'h32D
`define OFS_B_VA_PWR 12'h335
`define OFS_B_VA_EGY_LO 12'h336
`define OFS_B_VA_EGY_HI 12'h337
`define OFS_B_FVAR_PWR 12'h349
`define OFS_B_FVAR_EGY_LO 12'h34A
`define OFS_B_FVAR_EGY_HI 12'h34B
`define OFS_C_W_PWR 12'h35D
`define OFS_C_W_EGY_LO 12'h35E
`define OFS_C_W_EGY_HI 12'h35F
`define OFS_C_VAR_PWR 12'h367
`define OFS_C_VAR_EGY_LO 12'h368
`define OFS_C_VAR_EGY_HI 12'h369
`define OFS_C_VA_PWR 12'h371
`define OFS_C_VA_EGY_LO 12'h372
`define OFS_C_VA_EGY_HI 12'h373
`define OFS_C_FVAR_PWR 12'h385
`define OFS_C_FVAR_EGY_LO 12'h386
`define OFS_C_FVAR_EGY_HI 12'h387
`define OFS_POS_W_TOT 12'h397
`define OFS_NEG_W_TOT 12'h39B
`define OFS_POS_VAR_TOT 12'h39F
`define OFS_NEG_VAR_TOT 12'h3A3
`define OFS_I_PEAK 12'h400
`define OFS_V_PEAK 12'h401
`define OFS_STATUS_WORD_0 12'h402
`define OFS_STATUS_WORD_1 12'h403
`define OFS_EVENT_FLAGS 12'h404
`define OFS_IRQ_EN0 12'h405
`define OFS_IRQ_EN1 12'h406
`define OFS_EVENT_EN 12'h407
`define OFS_USER_PERIOD 12'h40E
`define OFS_FVAR_LEVEL 12'h40F
`define OFS_PERIOD_A 12'h418
`define OFS_PERIOD_B 12'h419
`define OFS_PERIOD_C 12'h41A
`define OFS_PERIOD_COMB 12'h41B

// reset values
`define RST_USER_PERIOD 32'h0050_0000
`define RST_FVAR_LEVEL 32'h0004_5D45
`define RST_LINE_PERIOD 32'h00A0_0000

// energy config fields, period format
`define EGY_CFG_EN_BIT 0
`define EGY_CFG_CLR_BIT 1
`define PERIOD_FRAC_BITS 16
`define CNT_W 16
`endif

// ### rtl/metering_pkg.sv
package metering_pkg;
  // instantaneous powers of one phase at 4 kSPS
  typedef struct packed {
    logic signed [31:0] act;
    logic signed [31:0] react;
    logic signed [31:0] appar;
    logic signed [31:0] fund_react;
  } phase_power_type;

  // instantaneous waveforms for peak holders
  typedef struct packed {
    logic signed [31:0] ia;
    logic signed [31:0] ib;
    logic signed [31:0] ic;
    logic signed [31:0] va;
    logic signed [31:0] vb;
    logic signed [31:0] vc;
  } waveform_type;

  // host register access port
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } reg_req_type;

  // one accumulation lane
  typedef struct packed {
    logic signed [63:0] pwr_sum;
    logic [31:0] pwr_out;
    logic signed [63:0] egy_sum;
    logic [63:0] egy_out;
  } accum_state_type;

  // whole result bank
  typedef struct packed {
    logic [15:0] pwr_cnt;
    logic [15:0] egy_cnt;
    logic signed [3:0][63:0] tot_sum;
    logic [3:0][31:0] tot_out;
    logic [31:0] i_peak;
    logic [31:0] v_peak;
    logic [31:0] status_word_0;
    logic [31:0] status_word_1;
    logic [31:0] irq_en0;
    logic [31:0] irq_en1;
    logic [31:0] event_en;
    logic [31:0] user_period;
    logic [31:0] fvar_level;
    logic [3:0][15:0] per_cnt;
    logic [3:0][31:0] per_out;
    logic [31:0] resample_period;
    logic [31:0] rdata;
    logic rd_valid;
  } bank_state_type;
endpackage : metering_pkg

// ### rtl/accum_unit.sv
`timescale 1ns/1ps
`include "metering_regs.svh"
module accum_unit (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // sample cadence and interval ends
  input wire logic smp,
  input wire logic pwr_last,
  input wire logic egy_last,
  input wire logic [1:0] egy_cfg,
  // sample in, results out
  input wire logic signed [31:0] din,
  output logic [31:0] pwr_out,
  output logic [63:0] egy_out
);
  metering_pkg::accum_state_type s_r;
  metering_pkg::accum_state_type s_nxt;
  logic signed [63:0] din_x;

  // sum samples; interval end latches the total
  always_comb begin
    s_nxt = s_r;
    din_x = 64'(din);
    if (smp) begin
      if (pwr_last) begin
        s_nxt.pwr_out = 32'(s_r.pwr_sum + din_x); // RL1 RL11
        s_nxt.pwr_sum = '0;
      end else begin
        s_nxt.pwr_sum = s_r.pwr_sum + din_x;
      end
      if (egy_cfg[`EGY_CFG_EN_BIT]) begin
        s_nxt.egy_sum = s_r.egy_sum + din_x;
      end
      if (egy_last) begin
        s_nxt.egy_out = s_nxt.egy_sum; // RL2 RL11
        // clearing makes each word pair one interval's energy
        if (egy_cfg[`EGY_CFG_CLR_BIT]) begin
          s_nxt.egy_sum = '0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pwr_out = s_r.pwr_out;
  assign egy_out = s_r.egy_out;

  sequence interval_end_s;
    smp && pwr_last;
  endsequence
  pwr_latch_sum_a: assert property (@(posedge clk) disable iff (!rst_n) // RL1
    interval_end_s |=> pwr_out == 32'($past(s_r.pwr_sum) + 64'($past(din))))
    else $error("power result not latched from interval sum");
  pwr_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // RL1
    !(smp && pwr_last) |=> $stable(pwr_out))
    else $error("power result moved between interval ends");
  egy_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // RL2
    !(smp && egy_last) |=> $stable(egy_out))
    else $error("energy words moved outside an energy interval end");
endmodule : accum_unit

// ### rtl/metering_result_register_bank.sv
`timescale 1ns/1ps
`include "metering_regs.svh"
module metering_result_register_bank (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // metrology sample cadence, 4 kSPS
  input wire logic sample_strobe,
  input wire metering_pkg::phase_power_type phase_a_power,
  input wire metering_pkg::phase_power_type phase_b_power,
  input wire metering_pkg::phase_power_type phase_c_power,
  input wire metering_pkg::waveform_type waves,
  // zero crossings: a, b, c, combined
  input wire logic [3:0] zero_cross,
  // configuration from other banks
  input wire logic [15:0] power_accum_interval,
  input wire logic [15:0] energy_accum_interval,
  input wire logic [1:0] energy_accum_config,
  input wire logic user_period_select,
  // hardware status and event sources
  input wire logic [31:0] status_word_0_set,
  input wire logic [31:0] status_word_1_set,
  input wire logic [31:0] event_level,
  // host register port
  input wire metering_pkg::reg_req_type req,
  output logic [31:0] rdata,
  output logic rd_valid,
  // results to the rest of the core
  output logic irq0_n,
  output logic irq1_n,
  output logic event_n,
  output logic [31:0] resample_period,
  output logic [31:0] fund_react_level
);
  metering_pkg::bank_state_type s_r;
  metering_pkg::bank_state_type s_nxt;

  localparam int LANES = 7;
  logic [LANES-1:0][31:0] lane_in;
  logic [LANES-1:0][31:0] lane_pwr;
  logic [LANES-1:0][63:0] lane_egy;
  logic pwr_last;
  logic egy_last;
  logic [16:0] pwr_cnt_inc;
  logic [16:0] egy_cnt_inc;
  logic [31:0] st0_clr;
  logic [31:0] st1_clr;
  logic [31:0] i_mag;
  logic [31:0] v_mag;
  logic [31:0] rd_mux;
  logic [2:0][31:0] act_in;
  logic [2:0][31:0] react_in;

  // interval ends; a zero interval behaves as one sample
  assign pwr_cnt_inc = {1'b0, s_r.pwr_cnt} + 17'h0_0001;
  assign egy_cnt_inc = {1'b0, s_r.egy_cnt} + 17'h0_0001;
  assign pwr_last = pwr_cnt_inc >= {1'b0, power_accum_interval};
  assign egy_last = egy_cnt_inc >= {1'b0, energy_accum_interval};

  // lanes: b var, b va, b fvar, c w, c var, c va, c fvar
  assign lane_in[0] = phase_b_power.react;
  assign lane_in[1] = phase_b_power.appar;
  assign lane_in[2] = phase_b_power.fund_react;
  assign lane_in[3] = phase_c_power.act;
  assign lane_in[4] = phase_c_power.react;
  assign lane_in[5] = phase_c_power.appar;
  assign lane_in[6] = phase_c_power.fund_react;

  // one accumulator per lane; phase a results and phase b active power have none
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    accum_unit u_acc (
      .clk(clk),
      .rst_n(rst_n),
      .smp(sample_strobe),
      .pwr_last(pwr_last),
      .egy_last(egy_last),
      .egy_cfg(energy_accum_config),
      .din(lane_in[g]),
      .pwr_out(lane_pwr[g]),
      .egy_out(lane_egy[g])
    );
  end

  assign act_in[0] = phase_a_power.act;
  assign act_in[1] = phase_b_power.act;
  assign act_in[2] = phase_c_power.act;
  assign react_in[0] = phase_a_power.react;
  assign react_in[1] = phase_b_power.react;
  assign react_in[2] = phase_c_power.react;

  // largest magnitude across the three phases
  function automatic logic [31:0] peak3(input logic [31:0] a, input logic [31:0] b,
                                        input logic [31:0] c);
    logic [31:0] ma;
    logic [31:0] mb;
    logic [31:0] mc;
    logic [31:0] m;
    ma = a[31] ? 32'(-a) : a;
    mb = b[31] ? 32'(-b) : b;
    mc = c[31] ? 32'(-c) : c;
    m = (ma > mb) ? ma : mb;
    return (m > mc) ? m : mc;
  endfunction : peak3

  assign i_mag = peak3(waves.ia, waves.ib, waves.ic);
  assign v_mag = peak3(waves.va, waves.vb, waves.vc);

  // write-one-to-clear masks for the status words
  assign st0_clr = (req.wr && req.addr == `OFS_STATUS_WORD_0) ? req.wdata : 32'h0000_0000;
  assign st1_clr = (req.wr && req.addr == `OFS_STATUS_WORD_1) ? req.wdata : 32'h0000_0000;

  // read decode; unmapped words read zero
  always_comb begin
    if (req.addr == `OFS_B_VAR_EGY_LO) begin
      rd_mux = lane_egy[0][31:0];
    end else if (req.addr == `OFS_B_VAR_EGY_HI) begin
      rd_mux = lane_egy[0][63:32];
    end else if (req.addr == `OFS_B_VA_PWR) begin
      rd_mux = lane_pwr[1];
    end else if (req.addr == `OFS_B_VA_EGY_LO) begin
      rd_mux = lane_egy[1][31:0];
    end else if (req.addr == `OFS_B_VA_EGY_HI) begin
      rd_mux = lane_egy[1][63:32];
    end else if (req.addr == `OFS_B_FVAR_PWR) begin
      rd_mux = lane_pwr[2];
    end else if (req.addr == `OFS_B_FVAR_EGY_LO) begin
      rd_mux = lane_egy[2][31:0];
    end else if (req.addr == `OFS_B_FVAR_EGY_HI) begin
      rd_mux = lane_egy[2][63:32];
    end else if (req.addr == `OFS_C_W_PWR) begin
      rd_mux = lane_pwr[3];
    end else if (req.addr == `OFS_C_W_EGY_LO) begin
      rd_mux = lane_egy[3][31:0];
    end else if (req.addr == `OFS_C_W_EGY_HI) begin
      rd_mux = lane_egy[3][63:32];
    end else if (req.addr == `OFS_C_VAR_PWR) begin
      rd_mux = lane_pwr[4];
    end else if (req.addr == `OFS_C_VAR_EGY_LO) begin
      rd_mux = lane_egy[4][31:0];
    end else if (req.addr == `OFS_C_VAR_EGY_HI) begin
      rd_mux = lane_egy[4][63:32];
    end else if (req.addr == `OFS_C_VA_PWR) begin
      rd_mux = lane_pwr[5];
    end else if (req.addr == `OFS_C_VA_EGY_LO) begin
      rd_mux = lane_egy[5][31:0];
    end else if (req.addr == `OFS_C_VA_EGY_HI) begin
      rd_mux = lane_egy[5][63:32];
    end else if (req.addr == `OFS_C_FVAR_PWR) begin
      rd_mux = lane_pwr[6];
    end else if (req.addr == `OFS_C_FVAR_EGY_LO) begin
      rd_mux = lane_egy[6][31:0];
    end else if (req.addr == `OFS_C_FVAR_EGY_HI) begin
      rd_mux = lane_egy[6][63:32];
    end else if (req.addr == `OFS_POS_W_TOT) begin
      rd_mux = s_r.tot_out[0];
    end else if (req.addr == `OFS_NEG_W_TOT) begin
      rd_mux = s_r.tot_out[1];
    end else if (req.addr == `OFS_POS_VAR_TOT) begin
      rd_mux = s_r.tot_out[2];
    end else if (req.addr == `OFS_NEG_VAR_TOT) begin
      rd_mux = s_r.tot_out[3];
    end else if (req.addr == `OFS_I_PEAK) begin
      rd_mux = s_r.i_peak;
    end else if (req.addr == `OFS_V_PEAK) begin
      rd_mux = s_r.v_peak;
    end else if (req.addr == `OFS_STATUS_WORD_0) begin
      rd_mux = s_r.status_word_0;
    end else if (req.addr == `OFS_STATUS_WORD_1) begin
      rd_mux = s_r.status_word_1;
    end else if (req.addr == `OFS_EVENT_FLAGS) begin
      rd_mux = event_level;
    end else if (req.addr == `OFS_IRQ_EN0) begin
      rd_mux = s_r.irq_en0;
    end else if (req.addr == `OFS_IRQ_EN1) begin
      rd_mux = s_r.irq_en1;
    end else if (req.addr == `OFS_EVENT_EN) begin
      rd_mux = s_r.event_en;
    end else if (req.addr == `OFS_USER_PERIOD) begin
      rd_mux = s_r.user_period;
    end else if (req.addr == `OFS_FVAR_LEVEL) begin
      rd_mux = s_r.fvar_level;
    end else if (req.addr == `OFS_PERIOD_A) begin
      rd_mux = s_r.per_out[0];
    end else if (req.addr == `OFS_PERIOD_B) begin
      rd_mux = s_r.per_out[1];
    end else if (req.addr == `OFS_PERIOD_C) begin
      rd_mux = s_r.per_out[2];
    end else if (req.addr == `OFS_PERIOD_COMB) begin
      rd_mux = s_r.per_out[3];
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  // next state of the whole bank
  always_comb begin
    s_nxt = s_r;
    s_nxt.rd_valid = req.rd;
    if (req.rd) begin
      s_nxt.rdata = rd_mux;
    end
    // sample counters for the two intervals
    if (sample_strobe) begin
      s_nxt.pwr_cnt = pwr_last ? 16'h0000 : pwr_cnt_inc[15:0];
      s_nxt.egy_cnt = egy_last ? 16'h0000 : egy_cnt_inc[15:0];
    end
    // signed totals split by sign of each phase
    if (sample_strobe) begin
      for (int p = 0; p < 3; p++) begin
        if (act_in[p][31]) begin
          s_nxt.tot_sum[1] = s_nxt.tot_sum[1] + 64'(signed'(act_in[p])); // RL4
        end else begin
          s_nxt.tot_sum[0] = s_nxt.tot_sum[0] + 64'(act_in[p]); // RL3
        end
        if (react_in[p][31]) begin
          s_nxt.tot_sum[3] = s_nxt.tot_sum[3] + 64'(signed'(react_in[p])); // RL5
        end else begin
          s_nxt.tot_sum[2] = s_nxt.tot_sum[2] + 64'(react_in[p]); // RL5
        end
      end
      if (pwr_last) begin
        for (int t = 0; t < 4; t++) begin
          s_nxt.tot_out[t] = s_nxt.tot_sum[t][63:32]; // RL3 RL4 RL5
          s_nxt.tot_sum[t] = '0;
        end
      end
    end
    // peaks restart on read so each read covers a fresh span
    if (req.rd && req.addr == `OFS_I_PEAK) begin
      s_nxt.i_peak = 32'h0000_0000;
    end
    if (req.rd && req.addr == `OFS_V_PEAK) begin
      s_nxt.v_peak = 32'h0000_0000;
    end
    if (sample_strobe && i_mag > s_nxt.i_peak) begin
      s_nxt.i_peak = i_mag;
    end
    if (sample_strobe && v_mag > s_nxt.v_peak) begin
      s_nxt.v_peak = v_mag;
    end
    // clear first, then set, so a coincident event survives
    s_nxt.status_word_0 = (s_r.status_word_0 & ~st0_clr) | status_word_0_set; // RL12
    s_nxt.status_word_1 = (s_r.status_word_1 & ~st1_clr) | status_word_1_set; // RL12
    // host-writable words
    if (req.wr) begin
      if (req.addr == `OFS_IRQ_EN0) begin
        s_nxt.irq_en0 = req.wdata;
      end else if (req.addr == `OFS_IRQ_EN1) begin
        s_nxt.irq_en1 = req.wdata;
      end else if (req.addr == `OFS_EVENT_EN) begin
        s_nxt.event_en = req.wdata;
      end else if (req.addr == `OFS_USER_PERIOD) begin
        s_nxt.user_period = req.wdata;
      end else if (req.addr == `OFS_FVAR_LEVEL) begin
        s_nxt.fvar_level = req.wdata; // RL10
      end
    end
    // line period in samples between crossings, 16.16 format
    if (sample_strobe) begin
      for (int k = 0; k < 4; k++) begin
        if (zero_cross[k]) begin
          s_nxt.per_out[k] = {s_r.per_cnt[k], 16'h0000}; // RL7 RL8
          s_nxt.per_cnt[k] = 16'h0001;
        end else if (s_r.per_cnt[k] != 16'hFFFF) begin
          s_nxt.per_cnt[k] = s_r.per_cnt[k] + 16'h0001;
        end
      end
    end
    // resampler period source
    s_nxt.resample_period = user_period_select ? s_r.user_period : s_r.per_out[3]; // RL6
  end

  // synchronous reset to the documented values
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.user_period <= `RST_USER_PERIOD; // RL6
      s_r.fvar_level <= `RST_FVAR_LEVEL; // RL10
      s_r.resample_period <= `RST_USER_PERIOD;
      for (int k = 0; k < 4; k++) begin
        s_r.per_out[k] <= `RST_LINE_PERIOD; // RL7
      end
    end else begin
      s_r <= s_nxt;
    end
  end

  // enables gate sticky status onto the irq lines and the unlatched event_level onto event_n
  assign irq0_n = ~|(s_r.status_word_0 & s_r.irq_en0); // RL9
  assign irq1_n = ~|(s_r.status_word_1 & s_r.irq_en1); // RL9
  assign event_n = ~|(event_level & s_r.event_en);
  assign rdata = s_r.rdata;
  assign rd_valid = s_r.rd_valid;
  assign resample_period = s_r.resample_period;
  assign fund_react_level = s_r.fvar_level;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence st0_write_one_s;
    req.wr && req.addr == `OFS_STATUS_WORD_0 && (req.wdata & ~status_word_0_set) != 32'h0000_0000;
  endsequence
  sequence host_sets_user_s;
    user_period_select && $stable(s_r.user_period);
  endsequence

  status_w1c_a: assert property (st0_write_one_s |=> // RL12
    (s_r.status_word_0 & $past(req.wdata & ~status_word_0_set)) == 32'h0000_0000)
    else $error("status bit not cleared by write of one");
  status_keep_a: assert property ($past(s_r.status_word_0) != 32'h0000_0000 && // RL12
    !(req.wr && req.addr == `OFS_STATUS_WORD_0) |-> ##0 1'b1 ##1
    ($past(s_r.status_word_0) & ~s_r.status_word_0) == 32'h0000_0000)
    else $error("status bit lost without a clearing write");
  status_set_wins_a: assert property (status_word_0_set != 32'h0000_0000 |=> // RL12
    (s_r.status_word_0 & $past(status_word_0_set)) == $past(status_word_0_set))
    else $error("status event lost against a clear");
  irq_gate_a: assert property ((status_word_0_set & s_r.irq_en0) != 32'h0000_0000 && // RL9
    !(req.wr && req.addr == `OFS_IRQ_EN0) |=> !irq0_n)
    else $error("enabled status did not raise the interrupt line");
  enables_reset_a: assert property (@(posedge clk) disable iff (1'b0) // RL9
    !rst_n |=> s_r.irq_en0 == 32'h0000_0000 && s_r.irq_en1 == 32'h0000_0000 &&
    s_r.user_period == `RST_USER_PERIOD && s_r.per_out[0] == `RST_LINE_PERIOD)
    else $error("reset values not taken");
  user_period_sel_a: assert property (host_sets_user_s ##1 host_sets_user_s |-> // RL6
    resample_period == s_r.user_period)
    else $error("resampler not using host period");
  period_capture_a: assert property (sample_strobe && zero_cross[3] |=> // RL8
    s_r.per_out[3] == {$past(s_r.per_cnt[3]), 16'h0000})
    else $error("combined period not captured at crossing");
  phase_period_a: assert property (sample_strobe && zero_cross[1] |=> // RL7
    s_r.per_out[1][15:0] == 16'h0000 && s_r.per_cnt[1] == 16'h0001)
    else $error("phase period capture wrong");
  totals_hold_a: assert property (!(sample_strobe && pwr_last) |=> $stable(s_r.tot_out)) // RL3
    else $error("totals moved outside an interval end");
  level_write_a: assert property (req.wr && req.addr == `OFS_FVAR_LEVEL |=> // RL10
    fund_react_level == $past(req.wdata))
    else $error("level constant not written");
endmodule : metering_result_register_bank

// ### dv/host_model.sv
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic clk,
  // register port toward the bank
  output metering_pkg::reg_req_type req,
  input wire logic [31:0] rdata,
  input wire logic rd_valid
);
  initial req = '0;

  // write: one taking edge, then address and data go stale on purpose
  task automatic write_reg(input logic [11:0] addr, input logic [31:0] data);
    @(posedge clk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
    @(posedge clk);
    req <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~data};
  endtask : write_reg

  // read: answer lands at the taking edge and is sampled just after it, else unknown
  task automatic read_reg(input logic [11:0] addr, output logic [31:0] data);
    @(posedge clk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 32'h0000_0000};
    @(posedge clk);
    req <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: 32'hFFFF_FFFF};
    #1;
    data = (rd_valid === 1'b1) ? rdata : 32'hXXXX_XXXX;
  endtask : read_reg
endmodule : host_model

// ### dv/metering_result_register_bank_test.sv
`timescale 1ns/1ps
module metering_result_register_bank_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sample_strobe = 1'b0;
  metering_pkg::phase_power_type pa, pb, pc;
  metering_pkg::waveform_type waves = '0;
  logic [3:0] zero_cross = 4'h0;
  logic [15:0] power_accum_interval = 16'h0002;
  logic [15:0] energy_accum_interval = 16'h0002;
  logic [1:0] energy_accum_config = 2'h1;
  logic user_period_select = 1'b0;
  logic [31:0] status_word_0_set = 32'h0, status_word_1_set = 32'h0, event_level = 32'h0;
  metering_pkg::reg_req_type req;
  logic [31:0] rdata, resample_period, fund_react_level;
  logic rd_valid, irq0_n, irq1_n, event_n;
  int n_mismatch = 0;
  int n_checks = 0;
  logic [11:0] adr [15];
  logic [31:0] val [15];

  always #2 clk = ~clk;

  metering_result_register_bank metering_result_register_bank_i (.clk(clk), .rst_n(rst_n),
    .sample_strobe(sample_strobe), .phase_a_power(pa), .phase_b_power(pb),
    .phase_c_power(pc), .waves(waves), .zero_cross(zero_cross),
    .power_accum_interval(power_accum_interval), .energy_accum_interval(energy_accum_interval),
    .energy_accum_config(energy_accum_config), .user_period_select(user_period_select),
    .status_word_0_set(status_word_0_set), .status_word_1_set(status_word_1_set), .event_level(event_level),
    .req(req), .rdata(rdata), .rd_valid(rd_valid), .irq0_n(irq0_n), .irq1_n(irq1_n),
    .event_n(event_n), .resample_period(resample_period), .fund_react_level(fund_react_level));

  host_model host_model_i (.clk(clk), .req(req), .rdata(rdata), .rd_valid(rd_valid));

  task automatic conclude();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_word

  task automatic chk_pin(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: pin %s got %b", $time, what, got);
    end
  endtask : chk_pin

  task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp);
    logic [31:0] d;
    host_model_i.read_reg(addr, d);
    chk_word(d, exp, $sformatf("read of %h", addr));
  endtask : rd_chk

  // one metrology sample with an optional zero-crossing pattern
  task automatic strobe(input logic [3:0] zc);
    @(posedge clk);
    sample_strobe <= 1'b1;
    zero_cross <= zc;
    @(posedge clk);
    sample_strobe <= 1'b0;
    zero_cross <= 4'h0;
    @(posedge clk);
  endtask : strobe

  // settle past the next edge so registered outputs are looked at late
  task automatic settle();
    @(posedge clk);
    #1;
  endtask : settle

  // hang guard, far beyond the roughly 160 cycles the run needs
  initial begin
    #(4 * 20000);
    n_mismatch++;
    conclude();
  end

  initial begin
    // phase a carries the positive reactive and negative active parts
    pa = '{act: 32'hC000_0000, react: 32'h4000_0000, appar: 32'h0, fund_react: 32'h0};
    pb = '{act: 32'h4000_0000, react: 32'hC000_0000, appar: 32'h4000_0000, fund_react: 32'h3};
    pc = pb;
    adr = '{12'h402, 12'h403, 12'h405, 12'h406, 12'h407, 12'h40E, 12'h40F, 12'h418,
            12'h419, 12'h41A, 12'h41B, 12'h35D, 12'h397, 12'h7FF, 12'h32D};
    val = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0050_0000, 32'h0004_5D45, 32'h00A0_0000,
            32'h00A0_0000, 32'h00A0_0000, 32'h00A0_0000, 32'h0, 32'h0, 32'h0, 32'h0};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 15; i++) rd_chk(adr[i], val[i]);
    chk_word(fund_react_level, 32'h0004_5D45, "level at reset");
    chk_pin(irq0_n, 1'b1, "irq0 at reset");
    // read-only period must ignore a host write
    host_model_i.write_reg(12'h418, 32'h1234_5678);
    rd_chk(12'h418, 32'h00A0_0000);
    host_model_i.write_reg(12'h40F, 32'h0001_2345);
    settle();
    chk_word(fund_react_level, 32'h0001_2345, "level after write");
    rd_chk(12'h40F, 32'h0001_2345);
    // sticky status, gated by enable, cleared only by ones
    @(posedge clk);
    status_word_0_set <= 32'h0000_0010;
    status_word_1_set <= 32'h0000_0001;
    @(posedge clk);
    status_word_0_set <= 32'h0;
    status_word_1_set <= 32'h0;
    settle();
    chk_pin(irq0_n, 1'b1, "irq0 masked");
    rd_chk(12'h402, 32'h0000_0010);
    host_model_i.write_reg(12'h405, 32'h0000_0010);
    host_model_i.write_reg(12'h406, 32'h0000_0001);
    settle();
    chk_pin(irq0_n, 1'b0, "irq0 enabled");
    chk_pin(irq1_n, 1'b0, "irq1 enabled");
    host_model_i.write_reg(12'h402, 32'hFFFF_FFEF);
    rd_chk(12'h402, 32'h0000_0010);
    host_model_i.write_reg(12'h402, 32'h0000_0010);
    rd_chk(12'h402, 32'h0);
    chk_pin(irq0_n, 1'b1, "irq0 after clear");
    // a fresh event on an enabled bit raises the line again
    @(posedge clk);
    status_word_0_set <= 32'h0000_0010;
    @(posedge clk);
    status_word_0_set <= 32'h0;
    event_level <= 32'h0000_0100;
    settle();
    chk_pin(irq0_n, 1'b0, "irq0 from enabled status");
    rd_chk(12'h404, 32'h0000_0100);
    chk_pin(event_n, 1'b1, "event masked");
    host_model_i.write_reg(12'h407, 32'h0000_0100);
    settle();
    chk_pin(event_n, 1'b0, "event enabled");
    // two samples close one power and one energy interval
    strobe(4'h0);
    strobe(4'h0);
    adr = '{12'h35D, 12'h367, 12'h371, 12'h385, 12'h349, 12'h335, 12'h35E, 12'h35F,
            12'h32C, 12'h32D, 12'h386, 12'h397, 12'h39B, 12'h39F, 12'h3A3};
    val = '{32'h8000_0000, 32'h8000_0000, 32'h8000_0000, 32'h6, 32'h6, 32'h8000_0000,
            32'h8000_0000, 32'h0, 32'h8000_0000, 32'hFFFF_FFFF, 32'h6, 32'h1,
            32'hFFFF_FFFF, 32'h0, 32'hFFFF_FFFF};
    for (int i = 0; i < 15; i++) rd_chk(adr[i], val[i]);
    // crossings three samples apart on every phase and the combined signal
    strobe(4'hF);
    strobe(4'h0);
    strobe(4'h0);
    strobe(4'hF);
    for (int k = 0; k < 4; k++) rd_chk(12'h418 + 12'(k), 32'h0003_0000);
    chk_word(resample_period, 32'h0003_0000, "measured period used");
    host_model_i.write_reg(12'h40E, 32'h0064_0000);
    user_period_select <= 1'b1;
    settle();
    settle();
    chk_word(resample_period, 32'h0064_0000, "user period used");
    // clear-at-end config: first snapshot still holds the running total, the next covers one interval only
    @(posedge clk);
    energy_accum_config <= 2'h3;
    strobe(4'h0);
    strobe(4'h0);
    rd_chk(12'h35F, 32'h0000_0002);
    strobe(4'h0);
    strobe(4'h0);
    rd_chk(12'h35F, 32'h0000_0000);
    rd_chk(12'h35E, 32'h8000_0000);
    conclude();
  end
endmodule : metering_result_register_bank_test
